/* File: rtl/clock_baud_regs.svh */
// Register indices, masks, codes and reset values of the clock block
`ifndef CLOCK_BAUD_REGS_SVH
`define CLOCK_BAUD_REGS_SVH
// ==========================================================
// Register indices (byte address is index times four)
`define IDX_RX_ANALOG 8'h39
`define IDX_UART_BAUD 8'h3B
`define IDX_OSC_TRIM 8'h3C
`define IDX_PLL_CTRL 8'h3D
`define IDX_PLL_OUTDIV 8'h3E
`define IDX_STATUS 8'h30
// ==========================================================
// Reset values and masks
`define RST_UART_BAUD 8'h7A
`define RST_ZERO 8'h00
`define RXA_WR_MASK 8'hCF
// ==========================================================
// Baud arithmetic
`define BAUD_LOW_ADD 13'h0001
`define BAUD_HIGH_ADD 13'h0021
// ==========================================================
// Feedback multiplication factors
`define FB_MULT_23 5'h17
`define FB_MULT_27 5'h1B
`define FB_MULT_28 5'h1C
// Usable output divider range
`define OUTDIV_MIN 8'h08
`define OUTDIV_MAX 8'hFE
// ==========================================================
// Clock pin source codes
`define SEL_GPIO 4'h0
`define SEL_PLL 4'h1
`define SEL_LOW 4'h2
`define SEL_HIGH 4'h3
`define SEL_XTAL 4'h4
`define SEL_XTAL_D2 4'h5
`define SEL_XTAL_D4 4'h6
`define SEL_XTAL_D8 4'h7
`define SEL_TMR0 4'h8
`define SEL_TMR3 4'hB
`endif

/* File: rtl/clock_baud_pkg.sv */
// Shared types of the clock and baud configuration block
package clock_baud_pkg;
    // ======================================================
    // Captured bus address phase
    typedef struct packed {
        logic valid;
        logic wr;
        logic ok;
        logic [7:0] idx;
    } ahb_req_s;
    // One serial character with its strobe
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } uart_byte_s;
    // Transmit sequencer states
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } tx_state_e;
endpackage

/* File: rtl/uart_frame_engine.sv */
// Serial character framing engine: one start, eight data, one stop bit
`timescale 1ns/1ps
`default_nettype none
module uart_frame_engine #(
    parameter int PERIOD_W = 13
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Bit period in reference cycles
    input wire logic [PERIOD_W-1:0] bit_period,
    // Serial lines, receive already synchronised
    input wire logic rx_line,
    output logic tx_line,
    // Transmit byte handshake
    input wire clock_baud_pkg::uart_byte_s tx_in,
    output logic tx_ready,
    // Received byte and frame check
    output clock_baud_pkg::uart_byte_s rx_out,
    output logic rx_frame_error
);
    import clock_baud_pkg::*;
    // ======================================================
    // Transmit side
    tx_state_e state_ff;
    logic [PERIOD_W-1:0] tcnt_ff; // Cycles left in bit
    logic [2:0] tbit_ff; // Data bit index
    logic [7:0] tshift_ff; // Bits still to send
    logic tx_line_ff; // Registered line level
    wire logic t_tick = tcnt_ff <= PERIOD_W'(1);
    wire logic [PERIOD_W-1:0] t_dec = tcnt_ff - PERIOD_W'(1);
    assign tx_ready = state_ff == TX_IDLE;
    assign tx_line = tx_line_ff;
    // Sequencer, line idles high between characters
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff <= TX_IDLE;
            tcnt_ff <= '0;
            tbit_ff <= 3'h0;
            tshift_ff <= 8'h00;
            tx_line_ff <= 1'b1;
        end else begin
            tcnt_ff <= t_tick ? bit_period : t_dec;
            case (state_ff)
                TX_IDLE: begin
                    tcnt_ff <= bit_period;
                    if (tx_in.valid) begin
                        // Start bit
                        state_ff <= TX_START;
                        tshift_ff <= tx_in.data;
                        tx_line_ff <= 1'b0;
                    end
                end
                TX_START: if (t_tick) begin
                    state_ff <= TX_DATA;
                    tbit_ff <= 3'h0;
                    tx_line_ff <= tshift_ff[0];
                    tshift_ff <= {1'b0, tshift_ff[7:1]};
                end
                TX_DATA: if (t_tick) begin
                    if (tbit_ff == 3'h7) begin
                        // Single stop bit, no parity
                        state_ff <= TX_STOP;
                        tx_line_ff <= 1'b1;
                    end else begin
                        tbit_ff <= tbit_ff + 3'h1;
                        tx_line_ff <= tshift_ff[0];
                        tshift_ff <= {1'b0, tshift_ff[7:1]};
                    end
                end
                TX_STOP: if (t_tick) begin
                    state_ff <= TX_IDLE;
                end
                default: state_ff <= TX_IDLE;
            endcase
        end
    end
    // ======================================================
    // Receive side, sampled at mid bit
    logic rbusy_ff; // Character in progress
    logic [PERIOD_W-1:0] rcnt_ff; // Cycles to next sample
    logic [3:0] rbit_ff; // 0 start, 1..8 data, 9 stop
    logic [7:0] rshift_ff; // Assembled data
    uart_byte_s rx_out_ff; // Output byte
    logic rerr_ff; // Stop bit was low
    wire logic r_tick = rcnt_ff <= PERIOD_W'(1);
    assign rx_out = rx_out_ff;
    assign rx_frame_error = rerr_ff;
    // Start detect, then one sample per bit period
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rbusy_ff <= 1'b0;
            rcnt_ff <= '0;
            rbit_ff <= 4'h0;
            rshift_ff <= 8'h00;
            rx_out_ff <= '0;
            rerr_ff <= 1'b0;
        end else begin
            rx_out_ff.valid <= 1'b0;
            if (!rbusy_ff) begin
                // Wait half a bit to land mid start bit
                if (!rx_line) begin
                    rbusy_ff <= 1'b1;
                    rcnt_ff <= bit_period >> 1;
                    rbit_ff <= 4'h0;
                end
            end else if (!r_tick) begin
                rcnt_ff <= rcnt_ff - PERIOD_W'(1);
            end else begin
                rcnt_ff <= bit_period;
                rbit_ff <= rbit_ff + 4'h1;
                if (rbit_ff == 4'h0 && rx_line) begin
                    // Glitch, not a start bit
                    rbusy_ff <= 1'b0;
                end else if (rbit_ff == 4'h9) begin
                    rbusy_ff <= 1'b0;
                    rx_out_ff <= '{data: rshift_ff, valid: 1'b1};
                    rerr_ff <= !rx_line;
                end else if (rbit_ff != 4'h0) begin
                    rshift_ff <= {rx_line, rshift_ff[7:1]};
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/clock_and_baud_config.sv */
// Clock configuration block: register slave, baud, trim, PLL and clock pin
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_baud_regs.svh"
// Function
// - Two-bit receiver high-pass corner at bits 3:2
// - Two-bit receiver gain at bits 1:0
// - Exponent zero: rate is reference over mantissa+1
// - Else reference over mantissa+33, over 2^(exp-1)
// - Characters: start, eight data, stop, no parity
// - Baud register resets to 7Ah
// - Larger oscillator trim lowers its frequency
// - PLL clock: input times feedback, halved, over divider
// - Feedback code gives 23, 27, 28, 23
// - Pin source 0 I/O, 1 PLL, 2 low, 3 high
// - Codes 4 to 7 give crystal over 1, 2, 4, 8
// - Codes 8 to B toggle on timer overflows
// - Clock pin enable gates the selected clock
// - Output divider divides by 8 to 254 only
module clock_and_baud_config #(
    parameter int PERIOD_W = 13
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // AHB-Lite slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Host serial pins
    input wire logic uart_rx_pin,
    output logic uart_tx_pin,
    // Character path to the core
    input wire clock_baud_pkg::uart_byte_s tx_byte,
    output logic tx_ready,
    output clock_baud_pkg::uart_byte_s rx_byte,
    output logic rx_frame_error,
    // Timer overflow pulses
    input wire logic [3:0] timer_overflow,
    // Clock output pin and pad bypass selects
    output logic clock_output_pin,
    output logic clock_output_oe,
    output logic clock_pin_pass_pll,
    output logic clock_pin_pass_ref,
    // Receiver analog settings
    output logic [1:0] mid_voltage_trim,
    output logic [1:0] rx_hp_corner,
    output logic [1:0] rx_gain,
    // Slow oscillator trim
    output logic [7:0] slow_osc_trim_value,
    output logic [7:0] slow_osc_speed_code,
    // PLL controls
    output logic pll_power_down,
    output logic [4:0] pll_feedback_mult,
    output logic [7:0] pll_output_divider,
    output logic pll_clock_valid
);
    import clock_baud_pkg::*;

    // ======================================================
    // Parameter check
    if (PERIOD_W < 13) begin : g_bad_width
        $error("PERIOD_W below 13 cannot hold the longest bit period");
    end

    // ======================================================
    // Functions
    // Bit period in reference cycles from the baud byte
    function automatic logic [PERIOD_W-1:0] baud_period(input logic [7:0] b);
        logic [PERIOD_W-1:0] mant;
        mant = PERIOD_W'(b[4:0]);
        if (b[7:5] == 3'h0) begin
            return mant + PERIOD_W'(`BAUD_LOW_ADD);
        end
        return (mant + PERIOD_W'(`BAUD_HIGH_ADD)) << (b[7:5] - 3'h1);
    endfunction

    // Feedback multiplication factor from its code
    function automatic logic [4:0] fb_mult(input logic [1:0] code);
        case (code)
            2'h1: return `FB_MULT_27;
            2'h2: return `FB_MULT_28;
            default: return `FB_MULT_23;
        endcase
    endfunction

    // Output divider setting inside its usable range
    function automatic logic div_ok(input logic [7:0] d);
        return d >= `OUTDIV_MIN && d <= `OUTDIV_MAX;
    endfunction

    // ======================================================
    // Bus address phase
    ahb_req_s req_ff; // Pending data phase
    logic [31:0] hrdata_ff; // Read data
    // Transfer accepted at this edge
    wire logic take = hsel && htrans[1] && hready;
    // Word aligned and inside the register window
    wire logic map_ok = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
    wire logic [7:0] rd_idx = haddr[9:2];
    // Never stalls, never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    // Capture address phase for the following data phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            req_ff <= '0;
        end else if (hready) begin
            req_ff <= '{valid: take, wr: hwrite, ok: map_ok, idx: rd_idx};
        end
    end

    // ======================================================
    // Write decode
    wire logic wr_live = req_ff.valid && req_ff.wr && req_ff.ok;
    wire logic wr_rxa = wr_live && req_ff.idx == `IDX_RX_ANALOG;
    wire logic wr_baud = wr_live && req_ff.idx == `IDX_UART_BAUD;
    wire logic wr_trim = wr_live && req_ff.idx == `IDX_OSC_TRIM;
    wire logic wr_pll = wr_live && req_ff.idx == `IDX_PLL_CTRL;
    wire logic wr_div = wr_live && req_ff.idx == `IDX_PLL_OUTDIV;

    // ======================================================
    // Configuration registers
    logic [7:0] rx_ana_ff; // Receiver analog settings
    logic [7:0] baud_ff; // Host UART baud
    logic [7:0] trim_ff; // Slow oscillator trim
    logic [7:0] pll_ctrl_ff; // PLL and clock pin control
    logic [7:0] outdiv_ff; // PLL output divider
    // Next values, write data taken in the data phase
    wire logic [7:0] nxt_rx_ana = wr_rxa ? hwdata[7:0] & `RXA_WR_MASK : rx_ana_ff;
    wire logic [7:0] nxt_baud = wr_baud ? hwdata[7:0] : baud_ff;
    wire logic [7:0] nxt_trim = wr_trim ? hwdata[7:0] : trim_ff;
    wire logic [7:0] nxt_pll_ctrl = wr_pll ? hwdata[7:0] : pll_ctrl_ff;
    wire logic [7:0] nxt_outdiv = wr_div ? hwdata[7:0] : outdiv_ff;

    // Register storage
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_ana_ff <= `RST_ZERO;
            baud_ff <= `RST_UART_BAUD;
            trim_ff <= `RST_ZERO;
            pll_ctrl_ff <= `RST_ZERO;
            outdiv_ff <= `RST_ZERO;
        end else begin
            rx_ana_ff <= nxt_rx_ana;
            baud_ff <= nxt_baud;
            trim_ff <= nxt_trim;
            pll_ctrl_ff <= nxt_pll_ctrl;
            outdiv_ff <= nxt_outdiv;
        end
    end

    // ======================================================
    // Read path
    wire logic [7:0] status = {5'h00, clock_output_oe, !tx_ready, pll_clock_valid};
    // Next values used so a read right after a write sees it
    wire logic [7:0] rd_val =
        !map_ok ? 8'h00 :
        rd_idx == `IDX_RX_ANALOG ? nxt_rx_ana :
        rd_idx == `IDX_UART_BAUD ? nxt_baud :
        rd_idx == `IDX_OSC_TRIM ? nxt_trim :
        rd_idx == `IDX_PLL_CTRL ? nxt_pll_ctrl :
        rd_idx == `IDX_PLL_OUTDIV ? nxt_outdiv :
        rd_idx == `IDX_STATUS ? status : 8'h00;

    // Read data loaded at the address phase
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata_ff <= {24'h00_0000, rd_val};
        end
    end

    // ======================================================
    // Analog settings
    // Trim bits passed as written; software keeps them zero
    assign mid_voltage_trim = rx_ana_ff[7:6];
    assign rx_hp_corner = rx_ana_ff[3:2];
    assign rx_gain = rx_ana_ff[1:0];
    assign slow_osc_trim_value = trim_ff;
    // Speed code falls as the trim rises
    assign slow_osc_speed_code = ~trim_ff;

    // ======================================================
    // PLL controls
    logic [4:0] mult_ff; // Feedback factor
    logic pll_ok_ff; // PLL source usable
    assign pll_power_down = pll_ctrl_ff[2];
    assign pll_feedback_mult = mult_ff;
    assign pll_output_divider = outdiv_ff;
    assign pll_clock_valid = pll_ok_ff;

    // Decoded from next values to stay aligned with registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mult_ff <= `FB_MULT_23;
            pll_ok_ff <= 1'b0;
        end else begin
            mult_ff <= fb_mult(nxt_pll_ctrl[1:0]);
            pll_ok_ff <= !nxt_pll_ctrl[2] && div_ok(nxt_outdiv);
        end
    end

    // ======================================================
    // Clock output pin
    logic [2:0] div_cnt_ff; // Crystal divider
    logic [3:0] tgl_ff; // Timer overflow toggles
    logic pin_ff; // Pin level
    logic oe_ff; // Pin driven
    logic pass_pll_ff; // Pad passes PLL clock
    logic pass_ref_ff; // Pad passes crystal clock
    wire logic [3:0] sel_w = pll_ctrl_ff[7:4];
    wire logic pin_en_w = pll_ctrl_ff[3];
    wire logic tmr_sel = sel_w >= `SEL_TMR0 && sel_w <= `SEL_TMR3;
    // Level for the pin from the selected source
    wire logic pin_src =
        sel_w == `SEL_HIGH ? 1'b1 :
        sel_w == `SEL_XTAL_D2 ? div_cnt_ff[0] :
        sel_w == `SEL_XTAL_D4 ? div_cnt_ff[1] :
        sel_w == `SEL_XTAL_D8 ? div_cnt_ff[2] :
        tmr_sel ? tgl_ff[sel_w[1:0]] : 1'b0;
    // I/O use and reserved codes leave the pin to the pad
    wire logic pin_drive = pin_en_w && sel_w != `SEL_GPIO && sel_w <= `SEL_TMR3;
    assign clock_output_pin = pin_ff;
    assign clock_output_oe = oe_ff;
    assign clock_pin_pass_pll = pass_pll_ff;
    assign clock_pin_pass_ref = pass_ref_ff;

    // Free dividers and toggles
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_cnt_ff <= 3'h0;
            tgl_ff <= 4'h0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 3'h1;
            tgl_ff <= tgl_ff ^ timer_overflow;
        end
    end

    // Pin outputs, all gated by the enable bit
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
            pass_pll_ff <= 1'b0;
            pass_ref_ff <= 1'b0;
        end else begin
            pin_ff <= pin_drive && pin_src;
            oe_ff <= pin_drive;
            pass_pll_ff <= pin_en_w && sel_w == `SEL_PLL && pll_ok_ff;
            pass_ref_ff <= pin_en_w && sel_w == `SEL_XTAL;
        end
    end

    // ======================================================
    // Host serial link
    logic rx_meta_ff; // First synchroniser stage
    logic rx_sync_ff; // Second synchroniser stage
    wire logic [PERIOD_W-1:0] bit_period = baud_period(baud_ff);

    // Pin synchroniser, idles high
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= uart_rx_pin;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    // Framing engine, rate taken from the baud register
    uart_frame_engine #(
        .PERIOD_W(PERIOD_W)
    ) u_frame (
        .core_clk(core_clk),
        .reset(reset),
        .bit_period(bit_period),
        .rx_line(rx_sync_ff),
        .tx_line(uart_tx_pin),
        .tx_in(tx_byte),
        .tx_ready(tx_ready),
        .rx_out(rx_byte),
        .rx_frame_error(rx_frame_error)
    );

    // ======================================================
    // Assertions
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (reset);

    rx_fields_a: assert property (
        wr_rxa |=> rx_gain == $past(hwdata[1:0]) && rx_hp_corner == $past(hwdata[3:2]))
        else $error("Receiver fields did not take the write");
    baud_low_a: assert property (
        baud_ff == 8'h15 |-> bit_period == 13'h0016)
        else $error("Low baud period wrong");
    baud_high_a: assert property (
        baud_ff == `RST_UART_BAUD |-> bit_period == 13'h00EC)
        else $error("High baud period wrong");
    frame_start_a: assert property (
        tx_byte.valid && tx_ready |=> !uart_tx_pin && !tx_ready)
        else $error("Start bit missing");
    frame_length_a: assert property (
        tx_byte.valid && tx_ready && bit_period == 13'h0016 && !wr_baud
        |-> ##220 (uart_tx_pin && !tx_ready) ##1 tx_ready)
        else $error("Character length wrong");
    baud_write_a: assert property (
        wr_baud |=> baud_ff == $past(hwdata[7:0]) && bit_period == baud_period(baud_ff))
        else $error("Baud register missed a write");
    osc_inverse_a: assert property (
        wr_trim |=> slow_osc_speed_code == ~$past(hwdata[7:0]))
        else $error("Trim code not inverted");
    out_div_a: assert property (
        wr_div |=> pll_output_divider == $past(hwdata[7:0]))
        else $error("Output divider not updated");
    fb_mult_a: assert property (
        pll_ctrl_ff[1:0] == 2'h2 |-> pll_feedback_mult == `FB_MULT_28)
        else $error("Feedback factor wrong");
    fb_wrap_a: assert property (
        pll_ctrl_ff[1:0] == 2'h3 |-> pll_feedback_mult == `FB_MULT_23)
        else $error("Feedback code 3 wrong");
    pin_low_a: assert property (
        pin_en_w && sel_w == `SEL_LOW |=> clock_output_oe && !clock_output_pin)
        else $error("Pin not held low");
    pin_high_a: assert property (
        pin_en_w && sel_w == `SEL_HIGH |=> clock_output_oe && clock_output_pin)
        else $error("Pin not held high");
    xtal_div_a: assert property (
        (pin_en_w && sel_w == `SEL_XTAL_D2) [*2]
        |=> clock_output_pin != $past(clock_output_pin))
        else $error("Divide by two not toggling");
    timer_tgl_a: assert property (
        pin_en_w && sel_w == `SEL_TMR0 && timer_overflow[0]
        ##1 (pin_en_w && sel_w == `SEL_TMR0)
        |=> clock_output_pin != $past(clock_output_pin))
        else $error("Timer toggle missing");
    gate_off_a: assert property (
        !pin_en_w |=> !clock_output_oe && !clock_pin_pass_pll && !clock_pin_pass_ref)
        else $error("Pin driven while disabled");
    pll_down_a: assert property (
        pll_ctrl_ff[2] |-> !pll_clock_valid ##1 !clock_pin_pass_pll)
        else $error("PLL used while powered down");
    div_range_a: assert property (
        outdiv_ff < `OUTDIV_MIN |-> !pll_clock_valid)
        else $error("Reserved divider accepted");

    baud_change_c: cover property (wr_baud ##1 baud_ff != `RST_UART_BAUD);
    timer_pin_c: cover property (pin_en_w && tmr_sel ##2 clock_output_pin);
    rx_byte_c: cover property (rx_byte.valid && !rx_frame_error);
    pll_pass_c: cover property (clock_pin_pass_pll);
endmodule
`default_nettype wire

/* File: verif/host_uart_model.sv */
// Host controller model on the serial link
`timescale 1ns/1ps
`default_nettype none
module host_uart_model (
    // Clock and bit period
    input wire logic core_clk,
    input wire logic [12:0] bit_cyc,
    // Serial lines
    input wire logic line_in,
    output logic line_out,
    // Frame to send and frame seen
    input wire logic go,
    input wire logic [7:0] send,
    output logic [7:0] got
);
    // Receive: sample mid-bit, least significant bit first
    always begin
        @(negedge line_in);
        repeat (bit_cyc / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge core_clk);
            got[i] = line_in;
        end
        repeat (bit_cyc) @(posedge core_clk);
    end
    // Send start, eight data and stop bits, then idle high
    initial begin
        line_out = 1'b1;
        forever begin
            @(posedge go);
            for (int i = 0; i < 10; i++) begin
                line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : send[i-1];
                repeat (bit_cyc) @(posedge core_clk);
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench of the clock and baud block
`timescale 1ns/1ps
`default_nettype none
`include "clock_baud_regs.svh"
module tb_top;
    import clock_baud_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic core_clk = 0, reset = 1, hsel = 0, hwrite = 0, hreadyout, hresp, go = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, mv, hp, gn;
    logic [3:0] tmr = 0;
    logic [7:0] got, send = 0, spd, trm, odv;
    logic [12:0] bc = 13'd236;
    logic rxp, txp, txr, rfe, pin, oe, ppll, pref, pd, pv;
    logic [4:0] fbm;
    uart_byte_s txb = '0, rxb;
    int miscompares = 0, tests_run = 0, cyc = 0;
    always #50 core_clk = ~core_clk;
    clock_and_baud_config #(.PERIOD_W(13)) clock_and_baud_config_i (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .uart_rx_pin(rxp),
        .uart_tx_pin(txp), .tx_byte(txb), .tx_ready(txr), .rx_byte(rxb), .rx_frame_error(rfe),
        .timer_overflow(tmr), .clock_output_pin(pin), .clock_output_oe(oe),
        .clock_pin_pass_pll(ppll), .clock_pin_pass_ref(pref), .mid_voltage_trim(mv),
        .rx_hp_corner(hp), .rx_gain(gn), .slow_osc_trim_value(trm), .slow_osc_speed_code(spd),
        .pll_power_down(pd), .pll_feedback_mult(fbm), .pll_output_divider(odv),
        .pll_clock_valid(pv));
    host_uart_model host_uart_model_i (.core_clk(core_clk), .bit_cyc(bc), .line_in(txp),
        .line_out(rxp), .go(go), .send(send), .got(got));
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One single AHB-Lite transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel <= 1; haddr <= {22'h0, idx, 2'b00}; htrans <= 2'b10; hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00; hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Control register write, then let outputs settle
    task automatic ctl(input logic [7:0] v);
        bus(1, `IDX_PLL_CTRL, {24'h0, v});
        repeat (3) @(posedge core_clk);
    endtask
    task automatic t_regs;
        bus(0, `IDX_UART_BAUD, 0); chk(rd, 32'h0000_007A);
        bus(1, `IDX_RX_ANALOG, 32'h0000_003F); bus(0, `IDX_RX_ANALOG, 0);
        chk(rd, 32'h0000_000F);
        chk({mv, hp, gn}, 6'h0F);
        bus(1, `IDX_OSC_TRIM, 32'h0000_005A); @(posedge core_clk);
        chk({trm, spd}, 16'h5AA5);
        bus(0, 8'h3F, 0); chk(rd, 0);
        chk(hresp, 0);
    endtask
    // Send one byte, time the start bit, check what the host saw
    task automatic t_tx(input logic [12:0] per);
        int n;
        n = 0;
        bc = per;
        txb <= {8'hA5, 1'b1};
        @(posedge core_clk);
        txb <= '0;
        while (txp !== 1'b0 && n < 9) begin @(posedge core_clk); n++; end
        n = 0;
        while (txp === 1'b0 && n < 300) begin @(posedge core_clk); n++; end
        chk(32'(n), {19'h0, per});
        n = 0;
        while (txr !== 1'b1 && n < 4000) begin @(posedge core_clk); n++; end
        chk(got, 8'hA5);
    endtask
    task automatic t_rx;
        int n;
        n = 0;
        send <= 8'h3C; go <= 1;
        while (rxb.valid !== 1'b1 && n < 400) begin @(posedge core_clk); n++; end
        go <= 0;
        chk({rfe, rxb.data}, 9'h03C);
    endtask
    task automatic t_pll;
        logic [4:0] m [4] = '{5'h17, 5'h1B, 5'h1C, 5'h17};
        for (int f = 0; f < 4; f++) begin
            ctl({6'h0, 2'(f)}); chk(fbm, m[f]);
        end
        bus(1, `IDX_PLL_OUTDIV, 32'h0000_0007); ctl(8'h00); chk(pv, 0);
        bus(1, `IDX_PLL_OUTDIV, 32'h0000_0008); ctl(8'h18); chk({pv, ppll}, 3);
        chk(odv, 8'h08);
        bus(0, `IDX_STATUS, 0);
        chk(rd, 32'h0000_0005);
        ctl(8'h04); chk({pd, pv}, 2'b10);
    endtask
    task automatic t_pin;
        logic p;
        ctl(8'h38); chk({oe, pin}, 2'b11);
        ctl(8'h28); chk({oe, pin}, 2'b10);
        ctl(8'h30); chk(oe, 0);
        ctl(8'h48); chk(pref, 1);
        ctl(8'h58); p = pin;
        @(posedge core_clk);
        chk(pin, !p);
        ctl(8'h08); chk(oe, 0);
        ctl(8'hC8); chk(oe, 0);
        ctl(8'h88); p = pin;
        tmr <= 4'h1; @(posedge core_clk); tmr <= 4'h0;
        repeat (3) @(posedge core_clk);
        chk(pin, !p);
    endtask
    task automatic conclude;
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin miscompares++; conclude(); end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 0;
        @(posedge core_clk);
        t_regs(); t_tx(13'd236);
        bus(1, `IDX_UART_BAUD, 32'h0000_0015);
        t_tx(13'd22); t_rx(); t_pll(); t_pin(); conclude();
    end
endmodule
`default_nettype wire
